// [logic/sdsl_dma_ctrl.sv]
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
module sdsl_dma_ctrl #(
  parameter int unsigned TOKEN_BITS = sdsl_pkg::TOKEN_W,
  parameter int unsigned LEN_BITS = sdsl_pkg::LEN_W
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [sdsl_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_send_buf_done,
  input wire logic i_send_last,
  input wire logic i_send_dscr_err,
  input wire logic i_send_underflow,
  input wire logic i_recv_buf_done,
  input wire logic i_recv_last,
  input wire logic i_recv_dscr_err,
  input wire logic i_recv_overflow,
  input wire logic i_link_clk,
  input wire logic i_host_vec_wr,
  input wire logic [sdsl_pkg::HOST_VEC_W-1:0] i_host_vec,
  input wire logic i_host_len_rd,
  output logic [31:0] o_send_dscr_addr,
  output logic [31:0] o_recv_dscr_addr,
  output logic o_send_active,
  output logic o_recv_active,
  output logic o_send_owner_wr,
  output logic o_recv_owner_wr,
  output logic o_irq,
  output logic [sdsl_pkg::HOST_VEC_W-1:0] o_to_host_irq,
  output logic [TOKEN_BITS-1:0] o_host_token,
  output logic [LEN_BITS-1:0] o_host_len
);
  import sdsl_pkg::*;

  // Widths are checked at elaboration, because the write fields of the
  // token and length registers have fixed positions and cannot grow.
  if (TOKEN_BITS == 0 || TOKEN_BITS > TOKEN_W) begin
    $error("sdsl_dma_ctrl: token width must fit its write field");
  end
  if (LEN_BITS == 0 || LEN_BITS > LEN_W) begin
    $error("sdsl_dma_ctrl: length width must fit its write field");
  end

  localparam int unsigned SYNC_W = 3 + HOST_VEC_W;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] dscr;
    logic [IRQ_N-1:0] raw;
    logic [IRQ_N-1:0] ena;
    logic [LIST_ADDR_W-1:0] send_list;
    logic [LIST_ADDR_W-1:0] recv_list;
    logic [2:0] send_cmd;
    logic [2:0] recv_cmd;
    logic [TOKEN_BITS-1:0] token;
    logic [LEN_BITS-1:0] len;
    logic [LEN_BITS-1:0] host_len;
    logic [HOST_VEC_W-1:0] to_host;
    logic irq;
    logic [2:0][SYNC_W-1:0] sync;
    logic link_q;
  } sdsl_ctrl_s;

  sdsl_ctrl_s r;
  sdsl_ctrl_s n;

  logic req;
  logic wr;
  logic [31:0] wm;
  logic [31:0] wv;
  logic [IRQ_N-1:0] set_vec;
  logic [IRQ_N-1:0] clr_vec;
  logic link_rise;
  logic [LIST_ADDR_W-1:0] send_addr;
  logic [LIST_ADDR_W-1:0] recv_addr;
  logic send_start_evt;
  logic send_done_evt;
  logic send_eof_evt;
  logic send_err_evt;
  logic recv_start_evt;
  logic recv_done_evt;
  logic recv_eof_evt;
  logic recv_err_evt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [31:0] m);
    merge = (old & ~m) | (dat & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sdsl_chain #(.ADDR_W(LIST_ADDR_W)) u_send (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_fsm_reset(r.cfg0[B_SEND_FSM_RESET]),
    .i_start(r.send_cmd[0]),
    .i_resume(r.send_cmd[1]),
    .i_halt(r.send_cmd[2]),
    .i_loop(r.cfg0[B_SEND_LOOP]),
    .i_writeback(r.cfg0[B_SEND_WRITEBACK]),
    .i_list_addr(r.send_list),
    .i_buf_done(i_send_buf_done),
    .i_last(i_send_last),
    .i_dscr_err(i_send_dscr_err),
    .o_addr(send_addr),
    .o_active(o_send_active),
    .o_owner_wr(o_send_owner_wr),
    .o_start_evt(send_start_evt),
    .o_done_evt(send_done_evt),
    .o_eof_evt(send_eof_evt),
    .o_err_evt(send_err_evt)
  );

  // The receive chain always hands ownership back unless looping.
  sdsl_chain #(.ADDR_W(LIST_ADDR_W)) u_recv (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_fsm_reset(r.cfg0[B_RECV_FSM_RESET]),
    .i_start(r.recv_cmd[0]),
    .i_resume(r.recv_cmd[1]),
    .i_halt(r.recv_cmd[2]),
    .i_loop(r.cfg0[B_RECV_LOOP]),
    .i_writeback(1'b1),
    .i_list_addr(r.recv_list),
    .i_buf_done(i_recv_buf_done),
    .i_last(i_recv_last),
    .i_dscr_err(i_recv_dscr_err),
    .o_addr(recv_addr),
    .o_active(o_recv_active),
    .o_owner_wr(o_recv_owner_wr),
    .o_start_evt(recv_start_evt),
    .o_done_evt(recv_done_evt),
    .o_eof_evt(recv_eof_evt),
    .o_err_evt(recv_err_evt)
  );

  assign o_send_dscr_addr = {MEM_REGION_HI, send_addr};
  assign o_recv_dscr_addr = {MEM_REGION_HI, recv_addr};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    req = i_wb_cyc & i_wb_stb & ~r.ack;
    wr = req & i_wb_we;
    wm = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
          {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wv = i_wb_dat & wm;
    link_rise = 1'b0;
    set_vec = '0;
    clr_vec = '0;
    n.ack = req;
    n.send_cmd = '0;
    n.recv_cmd = '0;
    n.to_host = '0;

    // Host pins: stage 1 feeds stage 2 only; stages 2 and 3 must agree, except the vector, taken from stage 3.
    n.sync[0] = {i_host_vec, i_host_len_rd, i_host_vec_wr, i_link_clk};
    n.sync[1] = r.sync[0];
    n.sync[2] = r.sync[1];
    if (r.sync[1][0] == r.sync[2][0] && r.sync[2][0] != r.link_q) begin
      n.link_q = r.sync[2][0];
      link_rise = r.sync[2][0];
    end
    if (link_rise && r.sync[2][1] && r.sync[1][1]) begin
      set_vec[HOST_VEC_W-1:0] = r.sync[2][SYNC_W-1:3];
    end
    if (link_rise && r.sync[2][2] && r.sync[1][2]) begin
      n.host_len = r.len;
    end

    set_vec[I_SEND_START] = send_start_evt;
    set_vec[I_RECV_START] = recv_start_evt;
    set_vec[I_SEND_UNDERFLOW] = i_send_underflow;
    set_vec[I_RECV_OVERFLOW] = i_recv_overflow;
    set_vec[I_RECV_BUF_DONE] = recv_done_evt;
    set_vec[I_RECV_FINISHED] = recv_eof_evt;
    set_vec[I_SEND_BUF_DONE] = send_done_evt;
    set_vec[I_SEND_FINISHED] = send_eof_evt;
    set_vec[I_RECV_DSCR_ERR] = recv_err_evt;
    set_vec[I_SEND_DSCR_ERR] = send_err_evt;

    if (wr) begin
      case (i_wb_adr)
        A_CONFIG0: n.cfg0 = merge(r.cfg0, i_wb_dat, wm & CFG0_MASK);
        A_CONFIG1: n.cfg1 = merge(r.cfg1, i_wb_dat, wm & CFG1_MASK);
        A_DSCR_CFG: n.dscr = merge(r.dscr, i_wb_dat, wm & DSCR_MASK);
        A_IRQ_ENABLE: n.ena = IRQ_N'(merge(32'(r.ena), i_wb_dat, wm));
        A_IRQ_CLEAR: clr_vec = wv[IRQ_N-1:0];
        A_SEND_LIST: begin
          n.send_list = LIST_ADDR_W'(merge(32'(r.send_list), i_wb_dat, wm));
          n.send_cmd = {wv[B_LIST_HALT], wv[B_LIST_RESUME],
                        wv[B_LIST_START]};
        end
        A_RECV_LIST: begin
          n.recv_list = LIST_ADDR_W'(merge(32'(r.recv_list), i_wb_dat, wm));
          n.recv_cmd = {wv[B_LIST_HALT], wv[B_LIST_RESUME],
                        wv[B_LIST_START]};
        end
        A_TO_HOST: n.to_host = wv[HOST_VEC_W-1:0];
        A_TOKEN: begin
          if (wv[B_TOKEN_ADD]) begin
            n.token = r.token
              + wv[TOKEN_WDATA_LSB +: TOKEN_BITS];
          end
        end
        A_LEN_UPDATE: begin
          if (wv[B_LEN_ADD]) begin
            n.len = r.len + wv[LEN_BITS-1:0];
          end
        end
        default: n.ack = req;
      endcase
    end

    // A flag raised in the cycle of its clear survives the clear.
    n.raw = (r.raw & ~clr_vec) | set_vec;
    n.irq = |(r.raw & r.ena);

    n.rdat = '0;
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        A_CONFIG0: n.rdat = r.cfg0;
        A_CONFIG1: n.rdat = r.cfg1;
        A_DSCR_CFG: n.rdat = r.dscr;
        A_IRQ_RAW: n.rdat = 32'(r.raw);
        A_IRQ_STATUS: n.rdat = 32'(r.raw & r.ena);
        A_IRQ_ENABLE: n.rdat = 32'(r.ena);
        A_SEND_LIST: n.rdat = 32'(r.send_list);
        A_RECV_LIST: n.rdat = 32'(r.recv_list);
        A_TOKEN: n.rdat = 32'(r.token);
        A_SENT_LEN: n.rdat = 32'(r.len);
        default: n.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      r <= '{cfg0: CFG0_RESET, cfg1: CFG1_RESET, dscr: DSCR_RESET,
             raw: IRQ_RESET, ena: IRQ_RESET, default: '0};
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.rdat;
  assign o_irq = r.irq;
  assign o_to_host_irq = r.to_host;
  assign o_host_token = r.token;
  assign o_host_len = r.host_len;

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms below are read only by the checks.
  logic host_rd_evt;
  logic host_wr_evt;
  assign host_rd_evt = link_rise & r.sync[2][2] & r.sync[1][2];
  assign host_wr_evt = link_rise & r.sync[2][1] & r.sync[1][1];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_clear_raw;
    i_clk_en && wr && i_wb_adr == A_IRQ_CLEAR
      |=> (r.raw & $past(clr_vec) & ~$past(set_vec)) == '0;
  endproperty
  a_clear_raw: assert property (p_clear_raw)
    else $error("clear write left a raw flag set");

  property p_set_wins;
    i_clk_en && (set_vec & clr_vec) != '0
      |=> (r.raw & $past(set_vec)) == $past(set_vec);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");

  property p_irq_out;
    i_clk_en |=> o_irq == $past(|(r.raw & r.ena));
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output does not follow status");

  sequence s_vec_write;
    i_clk_en && wr && i_wb_adr == A_TO_HOST && i_wb_sel[0];
  endsequence
  property p_to_host;
    s_vec_write |=> o_to_host_irq == $past(i_wb_dat[HOST_VEC_W-1:0])
      ##1 (!$past(i_clk_en) || o_to_host_irq == '0);
  endproperty
  a_to_host: assert property (p_to_host)
    else $error("slave-to-host vector not a single pulse");

  property p_token_add;
    i_clk_en && wr && i_wb_adr == A_TOKEN && wv[B_TOKEN_ADD]
      |=> r.token == TOKEN_BITS'($past(r.token)
        + $past(wv[TOKEN_WDATA_LSB +: TOKEN_BITS]));
  endproperty
  a_token_add: assert property (p_token_add)
    else $error("token count not advanced by written value");

  property p_len_add;
    i_clk_en && wr && i_wb_adr == A_LEN_UPDATE && wv[B_LEN_ADD]
      |=> r.len == LEN_BITS'($past(r.len) + $past(wv[LEN_BITS-1:0]));
  endproperty
  a_len_add: assert property (p_len_add)
    else $error("sent length not advanced by written value");

  property p_host_len;
    !$stable(o_host_len) |-> $past(host_rd_evt) && $past(i_clk_en);
  endproperty
  a_host_len: assert property (p_host_len)
    else $error("host length copy changed without a host read");

  property p_host_set;
    i_clk_en && host_wr_evt |=> (r.raw[HOST_VEC_W-1:0]
      & $past(r.sync[2][SYNC_W-1:3])) == $past(r.sync[2][SYNC_W-1:3]);
  endproperty
  a_host_set: assert property (p_host_set)
    else $error("host-to-slave flag not raised");

  property p_ack_single;
    o_wb_ack |=> !o_wb_ack || $past(!i_clk_en);
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("acknowledge longer than one cycle");
endmodule

// [logic/sdsl_pkg.sv]
// Function
// - With send owner write-back on and send loop-test off, each sent descriptor gets its owner bit rewritten.
// - Send loop-test wraps the send chain to its start and keeps owner bits.
// - Receive loop-test wraps the receive chain to its start and keeps owner bits.
// - The send FSM reset bit forces the send chain back to idle.
// - The receive FSM reset bit forces the receive chain back to idle.
// - Read-only raw flags exist for every chain event, error and flow fault.
// - Eight host-to-slave flags each have raw, status, enable and clear bits.
// - Every interrupt source, descriptor errors included, has a read-write enable bit.
// - Writing one to a clear bit clears that raw flag; zero does nothing.
// - Send start begins at the list address, resume continues, halt stops.
// - Receive start begins at the list address, resume continues, halt stops.
// - List address fields hold the low 20 bits; the region gives the rest.
// - Writing a slave-to-host vector bit raises that interrupt toward the host.
// - A read-only count of receive buffers offered to the host is kept.
// - The token add bit adds the written value to the count at once.
// - Sent length is read-only; the length add bit adds the written value.
// - Vector bits clear themselves, one interrupt per write.
// - The host copy of the sent length refreshes only on a host read.
// - The host sees the receive-buffer count through a read-only output.
package sdsl_pkg;

  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] A_CONFIG0 = 8'h00;
  localparam logic [7:0] A_IRQ_RAW = 8'h04;
  localparam logic [7:0] A_IRQ_STATUS = 8'h08;
  localparam logic [7:0] A_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] A_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] A_SEND_LIST = 8'h3c;
  localparam logic [7:0] A_RECV_LIST = 8'h40;
  localparam logic [7:0] A_TO_HOST = 8'h4c;
  localparam logic [7:0] A_TOKEN = 8'h54;
  localparam logic [7:0] A_CONFIG1 = 8'h60;
  localparam logic [7:0] A_DSCR_CFG = 8'h98;
  localparam logic [7:0] A_LEN_UPDATE = 8'he4;
  localparam logic [7:0] A_SENT_LEN = 8'he8;

  localparam int unsigned B_RECV_FSM_RESET = 0;
  localparam int unsigned B_SEND_FSM_RESET = 1;
  localparam int unsigned B_RECV_LOOP = 2;
  localparam int unsigned B_SEND_LOOP = 3;
  localparam int unsigned B_SEND_WRITEBACK = 4;
  localparam int unsigned B_TOKEN_AUTO_CLEAR = 5;
  localparam logic [31:0] CFG0_MASK = 32'h0000003f;
  localparam logic [31:0] CFG0_RESET = 32'h00000000;
  localparam logic [31:0] CFG1_MASK = 32'h00000007;
  localparam logic [31:0] CFG1_RESET = 32'h00000000;
  localparam logic [31:0] DSCR_MASK = 32'h00000001;
  localparam logic [31:0] DSCR_RESET = 32'h00000001;

  localparam int unsigned IRQ_N = 18;
  localparam int unsigned HOST_VEC_W = 8;
  localparam int unsigned I_SEND_START = 8;
  localparam int unsigned I_RECV_START = 9;
  localparam int unsigned I_SEND_UNDERFLOW = 10;
  localparam int unsigned I_RECV_OVERFLOW = 11;
  localparam int unsigned I_RECV_BUF_DONE = 12;
  localparam int unsigned I_RECV_FINISHED = 13;
  localparam int unsigned I_SEND_BUF_DONE = 14;
  localparam int unsigned I_SEND_FINISHED = 15;
  localparam int unsigned I_RECV_DSCR_ERR = 16;
  localparam int unsigned I_SEND_DSCR_ERR = 17;
  localparam logic [IRQ_N-1:0] IRQ_RESET = 18'h00000;

  localparam int unsigned LIST_ADDR_W = 20;
  localparam int unsigned B_LIST_HALT = 28;
  localparam int unsigned B_LIST_START = 29;
  localparam int unsigned B_LIST_RESUME = 30;
  localparam logic [19:0] DSCR_STEP = 20'h0000c;
  localparam logic [11:0] MEM_REGION_HI = 12'h3ff;

  localparam int unsigned TOKEN_W = 12;
  localparam int unsigned TOKEN_WDATA_LSB = 16;
  localparam int unsigned B_TOKEN_ADD = 28;
  localparam int unsigned LEN_W = 20;
  localparam int unsigned B_LEN_ADD = 20;

  typedef enum logic [2:0] {
    SDSL_IDLE = 3'b001,
    SDSL_RUN = 3'b010,
    SDSL_HALT = 3'b100
  } sdsl_chain_e;

endpackage

// [logic/sdsl_chain.sv]
`timescale 1ns/100ps
module sdsl_chain #(
  parameter int unsigned ADDR_W = sdsl_pkg::LIST_ADDR_W
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_fsm_reset,
  input wire logic i_start,
  input wire logic i_resume,
  input wire logic i_halt,
  input wire logic i_loop,
  input wire logic i_writeback,
  input wire logic [ADDR_W-1:0] i_list_addr,
  input wire logic i_buf_done,
  input wire logic i_last,
  input wire logic i_dscr_err,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_active,
  output logic o_owner_wr,
  output logic o_start_evt,
  output logic o_done_evt,
  output logic o_eof_evt,
  output logic o_err_evt
);
  import sdsl_pkg::*;

  // Refused at elaboration: the region bits above the field are fixed.
  if (ADDR_W == 0 || ADDR_W > LIST_ADDR_W) begin
    $error("sdsl_chain: unsupported address width");
  end

  typedef struct packed {
    sdsl_chain_e st;
    logic active;
    logic [ADDR_W-1:0] addr;
    logic owner_wr;
    logic start_evt;
    logic done_evt;
    logic eof_evt;
    logic err_evt;
  } sdsl_chain_s;

  sdsl_chain_s r;
  sdsl_chain_s n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.owner_wr = 1'b0;
    n.start_evt = 1'b0;
    n.done_evt = 1'b0;
    n.eof_evt = 1'b0;
    n.err_evt = 1'b0;
    if (i_fsm_reset) begin
      n.st = SDSL_IDLE;
    end else begin
      case (r.st)
        SDSL_IDLE: begin
          if (i_start) begin
            n.addr = i_list_addr;
            n.st = SDSL_RUN;
            n.start_evt = 1'b1;
          end
        end
        SDSL_RUN: begin
          if (i_halt) begin
            n.st = SDSL_HALT;
          end else if (i_dscr_err) begin
            n.err_evt = 1'b1;
            n.st = SDSL_HALT;
          end else if (i_buf_done) begin
            n.done_evt = 1'b1;
            // Loop-test reuses descriptors, so ownership must not move.
            n.owner_wr = i_writeback & ~i_loop;
            if (i_last && i_loop) begin
              n.addr = i_list_addr;
            end else if (i_last) begin
              n.st = SDSL_IDLE;
              n.eof_evt = 1'b1;
            end else begin
              n.addr = r.addr + DSCR_STEP[ADDR_W-1:0];
            end
          end
        end
        SDSL_HALT: begin
          if (i_start) begin
            n.addr = i_list_addr;
            n.st = SDSL_RUN;
            n.start_evt = 1'b1;
          end else if (i_resume) begin
            n.st = SDSL_RUN;
          end
        end
        default: n.st = SDSL_IDLE;
      endcase
    end
    // Registered copy of the run state keeps the output free of decode.
    n.active = (n.st == SDSL_RUN);
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      r <= '{st: SDSL_IDLE, default: '0};
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  assign o_addr = r.addr;
  assign o_active = r.active;
  assign o_owner_wr = r.owner_wr;
  assign o_start_evt = r.start_evt;
  assign o_done_evt = r.done_evt;
  assign o_eof_evt = r.eof_evt;
  assign o_err_evt = r.err_evt;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_fsm_reset;
    i_fsm_reset && i_clk_en |=> r.st == SDSL_IDLE && !o_start_evt;
  endproperty
  a_fsm_reset: assert property (p_fsm_reset)
    else $error("chain not idle after fsm reset");

  sequence s_last_in_loop;
    i_clk_en && r.st == SDSL_RUN && !i_fsm_reset && !i_halt && !i_dscr_err
      && i_buf_done && i_last && i_loop;
  endsequence
  property p_loop_wrap;
    s_last_in_loop |=> o_active && !o_owner_wr && !o_eof_evt
      && o_addr == $past(i_list_addr);
  endproperty
  a_loop_wrap: assert property (p_loop_wrap)
    else $error("loop test did not wrap cleanly");

  property p_owner_wb;
    i_clk_en && r.st == SDSL_RUN && !i_fsm_reset && !i_halt && !i_dscr_err
      && i_buf_done && i_writeback && !i_loop |=> o_owner_wr;
  endproperty
  a_owner_wb: assert property (p_owner_wb)
    else $error("owner write-back missing");
endmodule

// [testbench/sdsl_host_model.sv]
`timescale 1ns/100ps
module sdsl_host_model (
  input wire logic i_core_clk,
  output logic o_link_clk,
  output logic o_vec_wr,
  output logic [7:0] o_vec,
  output logic o_len_rd
);
  initial begin
    o_link_clk = 1'b0;
    o_vec_wr = 1'b0;
    o_vec = 8'h5a;
    o_len_rd = 1'b0;
  end
  // The link clock only moves inside an action, and the qualifiers settle
  // five core clocks ahead because the slave needs three to sync them.
  task automatic act(input logic w, input logic r, input logic [7:0] v);
    o_vec_wr <= w;
    o_vec <= v;
    o_len_rd <= r;
    repeat (5) @(posedge i_core_clk);
    o_link_clk <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    o_link_clk <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    o_vec_wr <= 1'b0;
    o_len_rd <= 1'b0;
    o_vec <= ~v;
  endtask
endmodule

// [testbench/sdsl_dma_ctrl_tb.sv]
`timescale 1ns/100ps
module sdsl_dma_ctrl_tb;
  import sdsl_pkg::*;
  logic clk, rst, cyc, stb, we, ack, irq, lclk, vwr, lrd, ce;
  logic [7:0] adr, vec, thi, ev, thc;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, sadr, radr, rd;
  logic [1:0] act, own;
  logic [11:0] tok;
  logic [19:0] hlen, l;
  int error_cnt, n_tests, seed, owncnt, thn, tok_m, len_m, n0;
  logic [7:0] v;
  logic [31:0] e;
  sdsl_dma_ctrl i_sdsl_dma_ctrl (.i_core_clk(clk), .i_reset(rst),
    .i_clk_en(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_send_buf_done(ev[0]), .i_send_last(ev[1]),
    .i_send_dscr_err(ev[2]), .i_send_underflow(ev[3]),
    .i_recv_buf_done(ev[4]), .i_recv_last(ev[5]),
    .i_recv_dscr_err(ev[6]), .i_recv_overflow(ev[7]),
    .i_link_clk(lclk), .i_host_vec_wr(vwr), .i_host_vec(vec),
    .i_host_len_rd(lrd), .o_send_dscr_addr(sadr),
    .o_recv_dscr_addr(radr), .o_send_active(act[0]),
    .o_recv_active(act[1]), .o_send_owner_wr(own[0]),
    .o_recv_owner_wr(own[1]), .o_irq(irq), .o_to_host_irq(thi),
    .o_host_token(tok), .o_host_len(hlen));
  sdsl_host_model i_sdsl_host_model (.i_core_clk(clk), .o_link_clk(lclk),
    .o_vec_wr(vwr), .o_vec(vec), .o_len_rd(lrd));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    owncnt += int'(own[0]) + int'(own[1]);
    if (thi !== 8'h00) begin
      thc = thi;
      thn++;
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 40);
    chk("wb_ack", 32'(ack), 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (4) @(posedge clk);
  endtask
  // Channel 0 is the send chain, channel 1 the receive chain.
  task automatic chain(int c);
    logic [7:0] la = c ? A_RECV_LIST : A_SEND_LIST;
    logic [19:0] a = 20'($random(seed)) & 20'hffff0;
    wb(1'b1, A_IRQ_CLEAR, 32'h3ffff);
    wb(1'b1, A_CONFIG0, c ? 32'h0 : 32'h10);
    wb(1'b1, la, {12'h200, a});
    owncnt = 0;
    chk("addr", c ? radr : sadr, {12'h3ff, a});
    pulse(c ? 8'h10 : 8'h01);
    chk("step", c ? radr : sadr, {12'h3ff, a + 20'h0000c});
    wb(1'b1, la, 32'h10000000);
    chk("halt", 32'(act[c]), 32'h0);
    wb(1'b1, la, 32'h40000000);
    chk("resume", c ? radr : sadr, {12'h3ff, a + 20'h0000c});
    pulse(c ? 8'h30 : 8'h03);
    chk("owner", owncnt, 2);
    wb(1'b0, A_IRQ_RAW, 0);
    chk("raw_ev", rd, c ? 32'h3200 : 32'hc100);
    wb(1'b1, A_CONFIG0, c ? 32'h4 : 32'h18);
    wb(1'b1, la, {12'h200, a});
    pulse(c ? 8'h30 : 8'h03);
    chk("wrap", c ? radr : sadr, {12'h3ff, a});
    chk("no_owner", owncnt, 2);
    pulse(c ? 8'hc0 : 8'h0c);
    wb(1'b0, A_IRQ_RAW, 0);
    chk("err", rd & 32'h30c00, c ? 32'h10800 : 32'h20400);
    wb(1'b1, la, {12'h200, a});
    wb(1'b1, A_CONFIG0, c ? 32'h1 : 32'h2);
    chk("fsm_rst", 32'(act[c]), 32'h0);
    wb(1'b1, A_CONFIG0, 32'h0);
    $display("test chain %0d done", c);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {rst, cyc, stb, we, adr, sel, wdat, ev} = {1'b1, 55'h0};
    ce = 1'b1;
    sel = 4'hf;
    seed = 32'hb7cd;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("addr_rst", sadr, 32'h3ff00000);
    wb(1'b0, A_DSCR_CFG, 0);
    chk("dscr_rst", rd, DSCR_RESET);
    wb(1'b0, 8'hfc, 0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, A_CONFIG1, 32'h0);
    wb(1'b1, A_DSCR_CFG, 32'h1);
    e = $random(seed) & 32'h1c;
    wb(1'b1, A_CONFIG0, e);
    wb(1'b0, A_CONFIG0, 0);
    chk("config0", rd, e & CFG0_MASK);
    wb(1'b1, A_CONFIG0, 32'h0);
    $display("test registers done");
    v = 8'($random(seed)) | 8'h81;
    i_sdsl_host_model.act(1'b1, 1'b0, v);
    wb(1'b0, A_IRQ_RAW, 0);
    chk("h2s_raw", rd, {24'h0, v});
    e = ($random(seed) & 32'h3ffff) | 32'h1;
    wb(1'b1, A_IRQ_ENABLE, e);
    wb(1'b0, A_IRQ_ENABLE, 0);
    chk("enable", rd, e);
    wb(1'b0, A_IRQ_STATUS, 0);
    chk("status", rd, e & {24'h0, v});
    chk("irq", 32'(irq), 32'h1);
    wb(1'b1, A_IRQ_RAW, 32'h0);
    wb(1'b1, A_IRQ_CLEAR, 32'h0f);
    wb(1'b0, A_IRQ_RAW, 0);
    chk("clear", rd, {24'h0, v & 8'hf0});
    ce <= 1'b0;
    pulse(8'h08);
    ce <= 1'b1;
    wb(1'b0, A_IRQ_RAW, 0);
    chk("freeze", rd & 32'h400, 32'h0);
    fork
      wb(1'b1, A_IRQ_CLEAR, 32'h400);
      pulse(8'h08);
    join
    wb(1'b0, A_IRQ_RAW, 0);
    chk("set_wins", rd & 32'h400, 32'h400);
    $display("test interrupts done");
    n0 = thn;
    wb(1'b1, A_TO_HOST, {24'h0, v});
    repeat (4) @(posedge clk);
    chk("s2h", {24'h0, thc}, {24'h0, v});
    chk("s2h_once", thn - n0, 1);
    for (int i = 0; i < 2; i++) begin
      e = $random(seed) & 32'hfff;
      l = 20'($random(seed));
      wb(1'b1, A_TOKEN, 32'h10000000 | (e << 16));
      tok_m = (tok_m + int'(e)) % 4096;
      wb(1'b0, A_TOKEN, 0);
      chk("token", rd & 32'hfff, 32'(tok_m));
      chk("host_token", 32'(tok), 32'(tok_m));
      wb(1'b1, A_LEN_UPDATE, {11'h0, 1'b1, l});
      chk("host_len_old", 32'(hlen), 32'(len_m));
      len_m = (len_m + int'(l)) % 1048576;
      wb(1'b0, A_SENT_LEN, 0);
      chk("sent_len", rd, 32'(len_m));
      i_sdsl_host_model.act(1'b0, 1'b1, 8'h00);
      chk("host_len", 32'(hlen), 32'(len_m));
    end
    $display("test counters done");
    chain(0);
    chain(1);
    report_and_stop;
  end
endmodule
